// ### design/mac_move_decode.sv
`timescale 1ns/1ps
// Contract
// RULE_01: signed accumulate adds the signed 64-bit product into acc_high:acc_low.
// RULE_02: unsigned accumulate adds the unsigned 64-bit product likewise.
// RULE_03: accumulation wraps and never raises an arithmetic exception.
// RULE_04: accumulate instructions write no general register.
// RULE_05: accumulates decode from major 011100, bits 15..6 zero, funct 0 or 1.
// RULE_06: multiply latency may shorten when the second operand is small.
// RULE_07: system move reads register index plus select into the target.
// RULE_08: the instruction source encodes select zero where unsupported.
// RULE_09: float move copies the low word of the float source, bits 10..0 zero.
// RULE_10: aux move passes the 16-bit selector and writes the returned word.
// RULE_11: float high move copies bits 63..32 of the float source.
// RULE_12: aux high move copies bits 63..32 of the selected aux register.
// RULE_13: pre-release-2 mode raises reserved instruction on high moves.
// RULE_14: acc halves commit together and readers interlock until done.
module mac_move_decode
   import mac_move_pkg::*;
(
   input  wire logic                     clk_in,
   input  wire logic                     nrst_in,
   input  wire mac_move_pkg::instr_s     instr_in,
   input  wire logic [31:0]              first_source_in,
   input  wire logic [31:0]              second_source_in,
   input  wire logic                     legacy_mode_in,
   input  wire logic                     acc_read_req_in,
   input  wire logic [31:0]              sys_coproc_data_in,
   input  wire logic [63:0]              float_source_in,
   input  wire logic [63:0]              aux_coproc_data_in,
   output logic                          instr_ready_out,
   output mac_move_pkg::reg_write_s      reg_write_out,
   output logic                          reserved_instr_out,
   output logic                          acc_stall_out,
   output logic [31:0]                   acc_high_out,
   output logic [31:0]                   acc_low_out,
   output logic [4:0]                    sys_reg_index_out,
   output logic [2:0]                    sys_reg_select_out,
   output logic [4:0]                    float_reg_index_out,
   output logic [15:0]                   aux_register_selector_out
);
   typedef struct packed {
      mac_state_e  state;
      logic [63:0] acc;
      reg_write_s  wr;
      logic        rsvd;
      logic [4:0]  sys_idx;
      logic [2:0]  sys_sel;
      logic [4:0]  flt_idx;
      logic [15:0] aux_sel;
      logic        busy;
      logic        ready;
   } top_s;

   top_s st_reg;
   top_s st_next;
   logic [31:0] w;
   logic [5:0]  opc;
   logic [4:0]  sub;
   logic        is_mac;
   logic        is_sys;
   logic        is_flt;
   logic        is_aux;
   logic        is_flt_hi;
   logic        is_aux_hi;
   logic        mul_start;
   logic        mul_done;
   logic [63:0] mul_sum;

   // decode; coprocessor read data is sampled with the instruction, the
   // index outputs only report which register was read
   always_comb
   begin
      w   = instr_in.word;
      opc = w[OPC_MSB:OPC_LSB];
      sub = w[SUB_MSB:SUB_LSB];
      is_mac = instr_in.valid && st_reg.state == ST_IDLE
               && opc == OP_EXT_MAJOR && w[15:6] == 10'h0
               && (w[5:0] == FN_MAC_SIGNED
                   || w[5:0] == FN_MAC_UNSIGN); // RULE_05
      is_sys = instr_in.valid && opc == OP_SYS_COPROC
               && sub == SUB_MOVE_FROM && w[10:3] == 8'h0; // RULE_07
      is_flt = instr_in.valid && opc == OP_FLT_COPROC
               && sub == SUB_MOVE_FROM && w[10:0] == 11'h0; // RULE_09
      is_aux = instr_in.valid && opc == OP_AUX_COPROC
               && sub == SUB_MOVE_FROM; // RULE_10
      is_flt_hi = instr_in.valid && opc == OP_FLT_COPROC
                  && sub == SUB_MOVE_HIGH && w[10:0] == 11'h0; // RULE_11
      is_aux_hi = instr_in.valid && opc == OP_AUX_COPROC
                  && sub == SUB_MOVE_HIGH; // RULE_12
      mul_start = is_mac;
   end

   mac_multiplier u_mul (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .start_in  (mul_start),
      .signed_in (w[5:0] == FN_MAC_SIGNED),
      .a_in      (first_source_in),
      .b_in      (second_source_in),
      .acc_in    (st_reg.acc),
      .done_out  (mul_done),
      .sum_out   (mul_sum)
   );

   always_comb
   begin
      st_next = st_reg;
      st_next.wr.valid = 1'b0;
      st_next.rsvd = 1'b0;
      st_next.wr.index = w[TGT_MSB:TGT_LSB];
      // move results land one cycle after the instruction
      case (st_reg.state)
         ST_IDLE:
            if (is_mac)
               st_next.state = ST_MUL;
         ST_MUL:
            if (mul_done)
            begin
               st_next.acc = mul_sum; // RULE_14
               st_next.state = ST_IDLE;
            end
         default:
            st_next.state = ST_IDLE;
      endcase
      st_next.busy  = st_next.state != ST_IDLE; // RULE_14
      st_next.ready = st_next.state == ST_IDLE;
      if ((is_flt_hi || is_aux_hi) && legacy_mode_in)
         st_next.rsvd = 1'b1; // RULE_13
      else if (is_sys)
      begin
         st_next.wr.valid = 1'b1;
         st_next.wr.data = sys_coproc_data_in; // RULE_07
      end
      else if (is_flt)
      begin
         st_next.wr.valid = 1'b1;
         st_next.wr.data = float_source_in[31:0]; // RULE_09
      end
      else if (is_flt_hi)
      begin
         st_next.wr.valid = 1'b1;
         st_next.wr.data = float_source_in[63:32]; // RULE_11
      end
      else if (is_aux)
      begin
         st_next.wr.valid = 1'b1;
         st_next.wr.data = aux_coproc_data_in[31:0]; // RULE_10
      end
      else if (is_aux_hi)
      begin
         st_next.wr.valid = 1'b1;
         st_next.wr.data = aux_coproc_data_in[63:32]; // RULE_12
      end
      // accumulate never raises a general register write
      if (is_mac)
         st_next.wr.valid = 1'b0; // RULE_04
      st_next.sys_idx = w[IDX_MSB:IDX_LSB];
      st_next.sys_sel = w[SEL_MSB:SEL_LSB]; // RULE_07
      st_next.flt_idx = w[IDX_MSB:IDX_LSB];
      st_next.aux_sel = w[15:0]; // RULE_10
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         st_reg <= '0;
         st_reg.state <= ST_IDLE;
         st_reg.acc <= ACC_RESET;
         st_reg.ready <= 1'b1;
      end
      else
         st_reg <= st_next;
   end

   // selector outputs are registered copies of the last word's fields
   assign instr_ready_out           = st_reg.ready;
   assign reg_write_out             = st_reg.wr;
   assign reserved_instr_out        = st_reg.rsvd;
   assign acc_stall_out             = st_reg.busy; // RULE_14
   assign acc_high_out              = st_reg.acc[63:32]; // RULE_01
   assign acc_low_out               = st_reg.acc[31:0];
   assign sys_reg_index_out         = st_reg.sys_idx;
   assign sys_reg_select_out        = st_reg.sys_sel;
   assign float_reg_index_out       = st_reg.flt_idx;
   assign aux_register_selector_out = st_reg.aux_sel;

   property p_stall_busy;
      @(posedge clk_in) disable iff (!nrst_in)
      mul_start |=> acc_stall_out;
   endproperty
   a_stall_busy: assert property (p_stall_busy) // RULE_14
      else $error("accumulate did not interlock");

   property p_mac_no_write;
      @(posedge clk_in) disable iff (!nrst_in)
      mul_start |=> !reg_write_out.valid;
   endproperty
   a_mac_no_write: assert property (p_mac_no_write) // RULE_04
      else $error("accumulate wrote a general register");

   property p_legacy_rsvd;
      @(posedge clk_in) disable iff (!nrst_in)
      (is_flt_hi && legacy_mode_in) |=> reserved_instr_out
         && !reg_write_out.valid;
   endproperty
   a_legacy_rsvd: assert property (p_legacy_rsvd) // RULE_13
      else $error("high move executed in legacy mode");

   property p_flt_hi;
      @(posedge clk_in) disable iff (!nrst_in)
      (is_flt_hi && !legacy_mode_in) |=>
         reg_write_out.data == $past(float_source_in[63:32]);
   endproperty
   a_flt_hi: assert property (p_flt_hi) // RULE_11
      else $error("float high move wrong data");

   property p_flt_lo;
      @(posedge clk_in) disable iff (!nrst_in)
      (is_flt && !is_mac) |=> reg_write_out.valid
         && reg_write_out.data == $past(float_source_in[31:0]);
   endproperty
   a_flt_lo: assert property (p_flt_lo) // RULE_09
      else $error("float move wrong data");

   property p_mac_done;
      @(posedge clk_in) disable iff (!nrst_in)
      mul_start |-> ##[2:6] !acc_stall_out;
   endproperty
   a_mac_done: assert property (p_mac_done) // RULE_06
      else $error("accumulate latency out of range");

   property p_mac_sum;
      @(posedge clk_in) disable iff (!nrst_in)
      (acc_stall_out && mul_done) |=> {acc_high_out, acc_low_out}
         == $past(mul_sum);
   endproperty
   a_mac_sum: assert property (p_mac_sum) // RULE_01
      else $error("accumulator not committed");

   property p_aux_sel;
      @(posedge clk_in) disable iff (!nrst_in)
      is_aux |=> aux_register_selector_out == $past(w[15:0]);
   endproperty
   a_aux_sel: assert property (p_aux_sel) // RULE_10
      else $error("aux selector altered");

   c_mac: cover property (@(posedge clk_in) mul_start);
   c_sys: cover property (@(posedge clk_in) is_sys);
   c_rsvd: cover property (@(posedge clk_in) reserved_instr_out);
endmodule : mac_move_decode

// ### design/mac_multiplier.sv
`timescale 1ns/1ps
module mac_multiplier
   import mac_move_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   input  wire logic        start_in,
   input  wire logic        signed_in,
   input  wire logic [31:0] a_in,
   input  wire logic [31:0] b_in,
   input  wire logic [63:0] acc_in,
   output logic             done_out,
   output logic [63:0]      sum_out
);
   typedef struct packed {
      logic        busy;
      logic [3:0]  count;
      logic        done;
      logic [63:0] sum;
   } mul_s;

   mul_s st_reg;
   mul_s st_next;
   logic [63:0] product;
   logic        short_b;

   always_comb
   begin
      // widen before multiplying so the upper half of the product survives
      if (signed_in)
         product = {{32{a_in[31]}}, a_in} * {{32{b_in[31]}}, b_in}; // RULE_01
      else
         product = {32'h0, a_in} * {32'h0, b_in}; // RULE_02
      // small second operand finishes early
      short_b = signed_in ? (b_in[31:15] == 17'h0 || b_in[31:15] == 17'h1FFFF)
                          : (b_in[31:16] == 16'h0); // RULE_06
   end

   always_comb
   begin
      st_next = st_reg;
      st_next.done = 1'b0;
      if (start_in && !st_reg.busy)
      begin
         st_next.busy = 1'b1;
         st_next.count = short_b ? MUL_LAT_SHORT : MUL_LAT_FULL;
         // wraps modulo 2^64, no overflow trap
         st_next.sum = acc_in + product; // RULE_03
      end
      else if (st_reg.busy)
      begin
         st_next.count = st_reg.count - 4'h1;
         if (st_reg.count == 4'h1)
         begin
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign done_out = st_reg.done;
   assign sum_out  = st_reg.sum;
endmodule : mac_multiplier

// ### dv/coproc_model.sv
`timescale 1ns/1ps
module coproc_model
(
   input  wire logic [31:0] word_in,
   output logic [31:0]      sys_data_out,
   output logic [63:0]      float_data_out,
   output logic [63:0]      aux_data_out
);
   import mac_move_pkg::*;
   // answers at once from the word's own fields; halves differ on purpose
   always_comb
   begin
      sys_data_out   = {24'hC3A55A, word_in[15:11], word_in[2:0]};
      float_data_out = {3'h5, word_in[15:11], 24'h123456,
                        3'h6, word_in[15:11], 24'h789ABC};
      aux_data_out   = {16'hBEEF, word_in[15:0], word_in[15:0], 16'h1234};
   end
endmodule : coproc_model

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import mac_move_pkg::*;
   logic        clk_in     = 1'b0;
   logic        nrst_in    = 1'b0;
   instr_s      instr      = '0;
   logic [31:0] op_a       = 32'h0;
   logic [31:0] op_b       = 32'h0;
   logic        legacy     = 1'b0;
   logic [31:0] sys_d;
   logic [63:0] flt_d;
   logic [63:0] aux_d;
   reg_write_s  wr;
   logic        ready;
   logic        resv;
   logic        stall;
   logic [31:0] acc_hi;
   logic [31:0] acc_lo;
   logic [4:0]  sys_idx;
   logic [2:0]  sys_sel;
   logic [4:0]  flt_idx;
   logic [15:0] aux_sel;
   logic [63:0] acc_exp    = 64'h0;
   int          err_total  = 0;
   int          n_compared = 0;
   int          cycles     = 0;

   always #12.5 clk_in = ~clk_in;

   mac_move_decode DUT (
      .clk_in(clk_in), .nrst_in(nrst_in), .instr_in(instr),
      .first_source_in(op_a), .second_source_in(op_b),
      .legacy_mode_in(legacy), .acc_read_req_in(1'b0),
      .sys_coproc_data_in(sys_d), .float_source_in(flt_d),
      .aux_coproc_data_in(aux_d), .instr_ready_out(ready),
      .reg_write_out(wr), .reserved_instr_out(resv),
      .acc_stall_out(stall), .acc_high_out(acc_hi), .acc_low_out(acc_lo),
      .sys_reg_index_out(sys_idx), .sys_reg_select_out(sys_sel),
      .float_reg_index_out(flt_idx), .aux_register_selector_out(aux_sel));

   coproc_model partner (
      .word_in(instr.word), .sys_data_out(sys_d),
      .float_data_out(flt_d), .aux_data_out(aux_d));

   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   function automatic logic [31:0] w_mac(input logic [5:0] fn);
      return {OP_EXT_MAJOR, 5'h01, 5'h02, 10'h000, fn};
   endfunction : w_mac

   task automatic issue(input logic [31:0] w, input logic [31:0] a, b);
      @(posedge clk_in);
      instr <= '{valid: 1'b1, word: w};
      op_a  <= a;
      op_b  <= b;
   endtask : issue

   task automatic idle;
      @(posedge clk_in);
      instr <= '0;
   endtask : idle

   // second word lands while busy and must be dropped
   task automatic t_mac(input logic [5:0] fn, input logic [31:0] a, b,
                        input logic twice);
      logic [63:0] p;
      logic        short_b;
      int          n;
      p = (fn == FN_MAC_SIGNED) ? {{32{a[31]}}, a} * {{32{b[31]}}, b}
                                : {32'h0, a} * {32'h0, b};
      // short when the second operand fits 16 bits of its own kind
      short_b = (fn == FN_MAC_SIGNED)
                ? (b[31:15] == 17'h0 || b[31:15] == 17'h1FFFF)
                : (b[31:16] == 16'h0);
      acc_exp = acc_exp + p;
      issue(w_mac(fn), a, b);
      if (twice)
         issue(w_mac(fn), b, a);
      idle;
      #1;
      check({stall, ready}, 2'h2);
      // edges from the start edge to the commit edge
      n = int'(twice);
      while (stall === 1'b1 && n < 8)
      begin
         @(posedge clk_in);
         #1;
         check(wr.valid, 1'b0);
         n++;
      end
      check({stall, ready}, 2'h1);
      check(n, short_b ? int'(MUL_LAT_SHORT) + 1
                       : int'(MUL_LAT_FULL) + 1);
      check({acc_hi, acc_lo}, acc_exp);
   endtask : t_mac

   // kind: 0 sys, 1 float, 2 aux, 3 float high, 4 aux high, 5 no match
   task automatic t_move(input logic [31:0] w, input int kind,
                         input logic lg);
      logic [31:0] d;
      logic        hi;
      hi = (w[SUB_MSB:SUB_LSB] == SUB_MOVE_HIGH) && kind < 5;
      issue(w, 32'h0, 32'h0);
      legacy <= lg;
      #1;
      case (kind)
         0: d = sys_d;
         1: d = flt_d[31:0];
         2: d = aux_d[31:0];
         3: d = flt_d[63:32];
         default: d = aux_d[63:32];
      endcase
      idle;
      #1;
      check({wr.valid, stall}, {kind < 5 && !(lg && hi), 1'b0});
      check(resv, lg && hi);
      if (wr.valid === 1'b1)
         check({wr.index, wr.data}, {w[TGT_MSB:TGT_LSB], d});
      if (kind == 0)
         check({sys_idx, sys_sel}, {w[15:11], w[2:0]});
      if (kind == 2 || kind == 4)
         check(aux_sel, w[15:0]);
      if (kind == 1 || kind == 3)
         check(flt_idx, w[15:11]);
   endtask : t_move

   always @(posedge clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         err_total++;
         wrap_up;
      end
   end

   initial
   begin
      repeat (2) @(posedge clk_in);
      nrst_in <= 1'b1;
      #1;
      check({acc_hi, acc_lo}, 64'h0);
      check({wr.valid, resv, stall, ready}, 4'h1);
      t_mac(FN_MAC_SIGNED, 32'hFFFFFFFD, 32'h00000007, 1'b0);
      t_mac(FN_MAC_SIGNED, 32'h80000000, 32'h80000000, 1'b1);
      t_mac(FN_MAC_UNSIGN, 32'hFFFFFFFF, 32'hFFFFFFFF, 1'b0);
      t_mac(FN_MAC_UNSIGN, 32'hFFFFFFFF, 32'h0000FFFF, 1'b0);
      for (int i = 0; i < 2; i++)
      begin
         t_move({OP_SYS_COPROC, SUB_MOVE_FROM, 5'h03, 5'h0C, 8'h00, 3'h0},
                0, i[0]);
         t_move({OP_SYS_COPROC, SUB_MOVE_FROM, 5'h04, 5'h10, 8'h00, 3'h5},
                0, i[0]);
         t_move({OP_FLT_COPROC, SUB_MOVE_FROM, 5'h05, 5'h1F, 11'h000},
                1, i[0]);
         t_move({OP_AUX_COPROC, SUB_MOVE_FROM, 5'h06, 16'hA5C3},
                2, i[0]);
         t_move({OP_FLT_COPROC, SUB_MOVE_HIGH, 5'h07, 5'h0A, 11'h000},
                3, i[0]);
         t_move({OP_AUX_COPROC, SUB_MOVE_HIGH, 5'h1E, 16'h5A3C},
                4, i[0]);
      end
      t_move({OP_FLT_COPROC, SUB_MOVE_FROM, 5'h05, 5'h1F, 11'h004},
             5, 1'b0);
      t_move(w_mac(FN_MAC_SIGNED) | 32'h00000040, 5, 1'b0);
      t_move(w_mac(6'h02), 5, 1'b0);
      check({acc_hi, acc_lo}, acc_exp);
      wrap_up;
   end
endmodule : tb_top

// ### inc/mac_move_pkg.sv
package mac_move_pkg;
   localparam logic [5:0] OP_EXT_MAJOR   = 6'h1C;
   localparam logic [5:0] OP_SYS_COPROC  = 6'h10;
   localparam logic [5:0] OP_FLT_COPROC  = 6'h11;
   localparam logic [5:0] OP_AUX_COPROC  = 6'h12;
   localparam logic [5:0] FN_MAC_SIGNED  = 6'h00;
   localparam logic [5:0] FN_MAC_UNSIGN  = 6'h01;
   localparam logic [4:0] SUB_MOVE_FROM  = 5'h00;
   localparam logic [4:0] SUB_MOVE_HIGH  = 5'h03;
   localparam int         OPC_MSB        = 31;
   localparam int         OPC_LSB        = 26;
   localparam int         SUB_MSB        = 25;
   localparam int         SUB_LSB        = 21;
   localparam int         SRC_MSB        = 25;
   localparam int         SRC_LSB        = 21;
   localparam int         TGT_MSB        = 20;
   localparam int         TGT_LSB        = 16;
   localparam int         IDX_MSB        = 15;
   localparam int         IDX_LSB        = 11;
   localparam int         SEL_MSB        = 2;
   localparam int         SEL_LSB        = 0;
   localparam int         WORD_W         = 32;
   localparam int         ACC_W          = 64;
   localparam logic [63:0] ACC_RESET     = 64'h0;
   localparam logic [3:0]  MUL_LAT_FULL  = 4'h4;
   localparam logic [3:0]  MUL_LAT_SHORT = 4'h1;

   typedef enum logic [1:0] {ST_IDLE, ST_MUL, ST_DONE} mac_state_e;

   typedef struct packed {
      logic        valid;
      logic [31:0] word;
   } instr_s;

   typedef struct packed {
      logic        valid;
      logic [4:0]  index;
      logic [31:0] data;
   } reg_write_s;
endpackage : mac_move_pkg
